// *** rtl/icfm_monitor.sv ***
// Input clock fault monitor top with Wishbone register slave
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module icfm_monitor
  import icfm_pkg::*;
#(
  parameter int PREC_GATE = 16000000,
  parameter int FAST_GATE = 1000,
  parameter int LOCK_GATE = 10000000
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic              wb_cyc_in,
  input  wire logic              wb_stb_in,
  input  wire logic              wb_we_in,
  input  wire logic [7:0]        wb_adr_in,
  input  wire logic [3:0]        wb_sel_in,
  input  wire logic [31:0]       wb_dat_in,
  output logic [31:0]            wb_dat_out,
  output logic                   wb_ack_out,
  input  wire logic [NUM_IN-1:0] ref_clk_in,
  input  wire logic              crystal_reference_in,
  input  wire logic              feedback_clk_in,
  output logic                   out_clk_out,
  output logic                   lock_loss_pin_n_out,
  output logic                   interrupt_pin_n_out
);
  localparam logic [CW-1:0] PREC_GATE_W = CW'(PREC_GATE);
  localparam logic [CW-1:0] FAST_GATE_W = CW'(FAST_GATE);
  localparam logic [CW-1:0] LOCK_GATE_W = CW'(LOCK_GATE);
  localparam logic [2:0]    OUT_HALF_W  = 3'(OUT_HALF_CYC - 1);

  typedef enum logic [1:0] {LK_LOST, LK_SETTLE, LK_LOCKED} icfm_lock_t;

  function automatic logic [CW-1:0] abs_diff(input logic [CW-1:0] a, input logic [CW-1:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : abs_diff

  function automatic logic [31:0] byte_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction : byte_merge

  logic [31:0]        ctrl_r;
  logic [31:0]        sens_r;
  logic [31:0]        prec_r;
  logic [31:0]        fast_r;
  logic [31:0]        lock_set_r;
  logic [31:0]        lock_clr_r;
  logic [31:0]        tmr_r;
  logic [31:0]        mask_r;
  logic [STAT_W-1:0]  sticky_r;
  logic [STAT_W-1:0]  live_w;
  logic [31:0]        dat_r;
  logic               ack_r;
  logic               req_w;
  logic               wr_w;

  logic [NUM_LOS:0]   edge_w;
  logic [NUM_LOS-1:0] loss_w;
  logic [NUM_LOS:0]   loss_all_w;
  logic [NUM_LOS:0]   mon_clk_w;

  // Bus handshake: ack one cycle after the request, write at the acked edge
  assign req_w      = wb_cyc_in & wb_stb_in;
  assign wr_w       = req_w & ack_r & wb_we_in;
  assign wb_ack_out = ack_r;
  assign wb_dat_out = dat_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else if (ce_in) begin
      ack_r <= req_w & ~ack_r;
      if (req_w && !ack_r) begin
        case (wb_adr_in)
          REG_CTRL:     dat_r <= ctrl_r;
          REG_LOS_SENS: dat_r <= sens_r;
          REG_PREC_WIN: dat_r <= prec_r;
          REG_FAST_THR: dat_r <= fast_r;
          REG_LOCK_SET: dat_r <= lock_set_r;
          REG_LOCK_CLR: dat_r <= lock_clr_r;
          REG_LOCK_TMR: dat_r <= tmr_r;
          REG_LIVE:     dat_r <= 32'(live_w);
          REG_STICKY:   dat_r <= 32'(sticky_r);
          REG_MASK:     dat_r <= mask_r;
          default:      dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r     <= CTRL_RESET;
      sens_r     <= SENS_RESET;
      prec_r     <= PREC_RESET;
      fast_r     <= FAST_RESET;
      lock_set_r <= LOCK_SET_RST;
      lock_clr_r <= LOCK_CLR_RST;
      tmr_r      <= TMR_RESET;
      mask_r     <= STAT_MASK;
    end else if (ce_in && wr_w) begin
      case (wb_adr_in)
        REG_CTRL:     ctrl_r     <= byte_merge(ctrl_r, wb_dat_in, wb_sel_in) & CTRL_MASK;
        REG_LOS_SENS: sens_r     <= byte_merge(sens_r, wb_dat_in, wb_sel_in) & SENS_MASK;
        REG_PREC_WIN: prec_r     <= byte_merge(prec_r, wb_dat_in, wb_sel_in) & PREC_MASK;
        REG_FAST_THR: fast_r     <= byte_merge(fast_r, wb_dat_in, wb_sel_in) & FAST_MASK;
        REG_LOCK_SET: lock_set_r <= byte_merge(lock_set_r, wb_dat_in, wb_sel_in) & LOCK_MASK;
        REG_LOCK_CLR: lock_clr_r <= byte_merge(lock_clr_r, wb_dat_in, wb_sel_in) & LOCK_MASK;
        REG_LOCK_TMR: tmr_r      <= byte_merge(tmr_r, wb_dat_in, wb_sel_in) & TMR_MASK;
        REG_MASK:     mask_r     <= byte_merge(mask_r, wb_dat_in, wb_sel_in) & STAT_MASK;
        default:      ctrl_r     <= ctrl_r;
      endcase
    end
  end

  logic       zdm_w;
  logic [2:0] ref_sel_w;
  logic [1:0] in_sel_w;
  assign zdm_w    = ctrl_r[CTRL_ZDM_BIT];
  assign in_sel_w = ctrl_r[CTRL_IN_SEL_LSB +: 2];
  // Input three is the feedback pin in zero-delay mode, never the reference
  assign ref_sel_w = (ctrl_r[CTRL_REF_SEL_LSB +: 3] > REF_SEL_IN3 ||
                      (zdm_w && ctrl_r[CTRL_REF_SEL_LSB +: 3] == REF_SEL_IN3)) ?
                     REF_SEL_XTAL : ctrl_r[CTRL_REF_SEL_LSB +: 3];

  // Watchers: inputs 0..3, crystal, feedback
  assign mon_clk_w = {feedback_clk_in, crystal_reference_in, ref_clk_in};
  for (genvar g = 0; g <= NUM_LOS; g++) begin : g_watch
    icfm_edge_watch u_watch (
      .clk_in     (clk_in),
      .rst_n_in   (rst_n_in),
      .ce_in      (ce_in),
      .mon_clk_in (mon_clk_w[g]),
      .enable_in  ((g < NUM_LOS) ? ctrl_r[CTRL_LOS_EN_LSB + ((g < NUM_LOS) ? g : 0)] : 1'b0),
      .sens_in    (sens_r[SENS_W*((g < NUM_LOS) ? g : 0) +: SENS_W]),
      .edge_out   (edge_w[g]),
      .loss_out   (loss_all_w[g])
    );
  end
  // Feedback watcher only supplies edges; it is never enabled for loss
  assign loss_w = loss_all_w[NUM_LOS-1:0];

  // Frequency monitors: input edges counted over a gate of reference edges
  logic              ref_edge_w;
  logic              ref_bad_w;
  logic [CW-1:0]     pgate_r;
  logic [CW-1:0]     fgate_r;
  logic [CW-1:0]     pcnt_r [NUM_IN];
  logic [CW-1:0]     fcnt_r [NUM_IN];
  logic [NUM_IN-1:0] prec_oof_r;
  logic [NUM_IN-1:0] fast_oof_r;
  logic [NUM_IN-1:0] oof_w;
  logic [CW-1:0]     win_w;
  logic [CW-1:0]     hyst_w;
  logic [CW-1:0]     fthr_w;

  assign ref_edge_w = (ref_sel_w == REF_SEL_XTAL) ? edge_w[XTAL_IDX] : edge_w[ref_sel_w - 3'h1];
  assign ref_bad_w  = (ref_sel_w == REF_SEL_XTAL) ? loss_w[XTAL_IDX] : loss_w[ref_sel_w - 3'h1];
  assign win_w      = CW'(prec_r[12:0]);
  assign hyst_w     = CW'(prec_r[28:16]);
  assign fthr_w     = CW'(fast_r[3:0]) + CW'(1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pgate_r    <= '0;
      fgate_r    <= '0;
      prec_oof_r <= '0;
      fast_oof_r <= '0;
      for (int i = 0; i < NUM_IN; i++) begin
        pcnt_r[i] <= '0;
        fcnt_r[i] <= '0;
      end
    end else if (ce_in && !ref_bad_w) begin
      pgate_r <= (pgate_r == PREC_GATE_W) ? '0 : pgate_r + CW'(ref_edge_w);
      fgate_r <= (fgate_r == FAST_GATE_W) ? '0 : fgate_r + CW'(ref_edge_w);
      for (int i = 0; i < NUM_IN; i++) begin
        if (pgate_r == PREC_GATE_W) begin
          pcnt_r[i] <= CW'(edge_w[i]);
          // Hysteresis: set above window, clear only well inside
          if (abs_diff(pcnt_r[i], PREC_GATE_W) > win_w) begin
            prec_oof_r[i] <= 1'b1;
          end else if (abs_diff(pcnt_r[i], PREC_GATE_W) + hyst_w <= win_w) begin
            prec_oof_r[i] <= 1'b0;
          end
        end else begin
          pcnt_r[i] <= pcnt_r[i] + CW'(edge_w[i]);
        end
        if (fgate_r == FAST_GATE_W) begin
          fcnt_r[i]     <= CW'(edge_w[i]);
          fast_oof_r[i] <= abs_diff(fcnt_r[i], FAST_GATE_W) >= fthr_w;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + CW'(edge_w[i]);
        end
      end
    end
  end

  assign oof_w = ({NUM_IN{ctrl_r[CTRL_PREC_EN]}} & prec_oof_r) |
                 ({NUM_IN{ctrl_r[CTRL_FAST_EN]}} & fast_oof_r);

  // Lock monitor: feedback edges over a gate of selected-input edges
  icfm_lock_t    lk_r;
  logic [1:0]    last_sel_r;
  logic [CW-1:0] lgate_r;
  logic [CW-1:0] fbcnt_r;
  logic [23:0]   timer_r;
  logic          sel_edge_w;
  logic          fb_edge_w;
  logic          switch_w;
  logic          meas_w;
  logic [CW-1:0] ldiff_w;
  logic          lk_set_w;
  logic          lk_clr_w;
  logic          lock_loss_w;

  assign sel_edge_w  = edge_w[in_sel_w];
  assign fb_edge_w   = zdm_w ? edge_w[NUM_IN - 1] : edge_w[NUM_LOS];
  assign switch_w    = in_sel_w != last_sel_r;
  assign meas_w      = lgate_r == LOCK_GATE_W;
  assign ldiff_w     = abs_diff(fbcnt_r, LOCK_GATE_W);
  assign lk_set_w    = ldiff_w > CW'(lock_set_r[16:0]);
  assign lk_clr_w    = ldiff_w <= CW'(lock_clr_r[16:0]);
  assign lock_loss_w = lk_r != LK_LOCKED;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      last_sel_r <= 2'h0;
      lgate_r    <= '0;
      fbcnt_r    <= '0;
    end else if (ce_in) begin
      last_sel_r <= in_sel_w;
      if (switch_w || meas_w) begin
        lgate_r <= '0;
        fbcnt_r <= '0;
      end else begin
        lgate_r <= lgate_r + CW'(sel_edge_w);
        fbcnt_r <= fbcnt_r + CW'(fb_edge_w);
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      lk_r    <= LK_LOST;
      timer_r <= 24'h00_0000;
    end else if (ce_in) begin
      if (switch_w || loss_w[in_sel_w]) begin
        lk_r <= LK_LOST;
      end else begin
        case (lk_r)
          LK_LOST: begin
            timer_r <= 24'h00_0000;
            if (meas_w && lk_clr_w) begin
              // Fast acquisition or no timer: lock declared at once
              lk_r <= (ctrl_r[CTRL_TIMER_EN] && !ctrl_r[CTRL_FAST_ACQ]) ?
                      LK_SETTLE : LK_LOCKED;
            end
          end
          LK_SETTLE: begin
            if (meas_w && lk_set_w) begin
              lk_r <= LK_LOST;
            end else if (timer_r >= tmr_r[23:0]) begin
              lk_r <= LK_LOCKED;
            end else begin
              timer_r <= timer_r + 24'h00_0001;
            end
          end
          LK_LOCKED: begin
            if (meas_w && lk_set_w) begin
              lk_r <= LK_LOST;
            end
          end
          default: lk_r <= LK_LOST;
        endcase
      end
    end
  end

  assign lock_loss_pin_n_out = ~lock_loss_w;

  // Status: live, sticky (set wins over clear), masked interrupt
  logic [STAT_W-1:0] clr_w;
  assign live_w = {lock_loss_w, 4'b0000, oof_w, 3'b000, loss_w};
  assign clr_w  = (wr_w && wb_adr_in == REG_STICKY) ?
                  STAT_W'(byte_merge(32'h0000_0000, wb_dat_in, wb_sel_in)) : '0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sticky_r <= '0;
    end else if (ce_in) begin
      sticky_r <= (sticky_r & ~clr_w) | live_w;
    end
  end

  assign interrupt_pin_n_out = ~|(sticky_r & ~mask_r[STAT_W-1:0]);

  // Output clock: enable changes only before a rising edge, so full periods only
  logic       xtal_stop_w;
  logic [2:0] div_r;
  logic       oclk_r;
  assign xtal_stop_w = loss_w[XTAL_IDX] & ~ctrl_r[CTRL_XTAL_KEEP];
  assign out_clk_out = oclk_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      div_r  <= 3'h0;
      oclk_r <= 1'b0;
    end else if (ce_in) begin
      if (div_r == OUT_HALF_W) begin
        div_r <= 3'h0;
        if (oclk_r) begin
          oclk_r <= 1'b0;
        end else begin
          oclk_r <= ~xtal_stop_w;
        end
      end else begin
        div_r <= div_r + 3'h1;
      end
    end
  end

  ack_one_cycle_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && wb_ack_out) |=> !wb_ack_out)
    else $error("ack held for more than one cycle");

  sticky_follows_live_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && |live_w) |=> ((sticky_r & $past(live_w)) == $past(live_w)))
    else $error("sticky bit missed a live event");

  sticky_holds_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !(wr_w && wb_adr_in == REG_STICKY)) |=> ((sticky_r & $past(sticky_r)) == $past(sticky_r)))
    else $error("sticky bit dropped without a host write");

  irq_from_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (|(sticky_r & ~mask_r[STAT_W-1:0])) == !interrupt_pin_n_out)
    else $error("interrupt pin disagrees with masked sticky bits");

  lock_pin_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    lock_loss_pin_n_out == (lk_r == LK_LOCKED))
    else $error("lock pin disagrees with lock state");

  switch_lock_loss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && switch_w) |=> (lk_r == LK_LOST) ##1 !lock_loss_pin_n_out[*2])
    else $error("lock loss not held after input switch");

  zdm_ref_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    zdm_w |-> (ref_sel_w != REF_SEL_IN3))
    else $error("feedback input used as frequency reference");

  xtal_stop_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && xtal_stop_w && !oclk_r) |=> !$rose(oclk_r))
    else $error("output clock started during crystal loss");

  no_runt_a: assert property (@(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    $rose(oclk_r) |-> oclk_r[*4])
    else $error("shortened output high phase");

  oof_disable_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!ctrl_r[CTRL_PREC_EN] && !ctrl_r[CTRL_FAST_EN]) |-> (oof_w == '0))
    else $error("frequency status set with both monitors off");
endmodule : icfm_monitor
`default_nettype wire

// *** rtl/icfm_pkg.sv ***
// Constants and register map of the input clock fault monitor
// Summary of operation
// - Switching between inputs up to 40 ppm apart pulls in, fast mode optional.
// - Lock loss stays asserted while pulling in after an input switch.
// - Input switching never produces shortened pulses on the output clock.
// - In zero-delay mode input three cannot be the frequency reference.
// - All four inputs watched for loss and frequency; crystal watched for loss.
// - Loss detectors time every period, each with its own sensitivity.
// - Each loss detector has a live bit and a sticky bit.
// - Each loss detector can be disabled.
// - Output clock stops during crystal loss unless configured to keep running.
// - Frequency reference selectable as crystal or any of four inputs.
// - Frequency status combines precise and fast monitors, each disableable.
// - Each frequency detector has a live bit and a sticky bit.
// - Precise monitor resolves inputs to a sixteenth of a ppm against the reference.
// - Precise window up to 500 ppm in sixteenth-ppm steps, with hysteresis.
// - Fast monitor flags moves of 1000 to 16000 ppm quickly.
// - Lock loss sets a status bit and drives an active-low pin.
// - Lock loss set and cleared by two separate frequency thresholds.
// - Set and clear thresholds programmable from 0.1 to 10000 ppm.
// - Lock loss has a live bit and a sticky bit.
// - Optional timer delays clearing of lock loss.
// - Interrupt pin asserts on any status, each with its own mask.
// - Interrupt comes from sticky bits and releases once host clears them.
package icfm_pkg;
  localparam int NUM_IN   = 4;
  localparam int NUM_LOS  = 5;
  localparam int XTAL_IDX = 4;
  localparam int CW       = 26;
  localparam int STAT_W   = 17;

  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_LOS_SENS = 8'h04;
  localparam logic [7:0] REG_PREC_WIN = 8'h08;
  localparam logic [7:0] REG_FAST_THR = 8'h0c;
  localparam logic [7:0] REG_LOCK_SET = 8'h10;
  localparam logic [7:0] REG_LOCK_CLR = 8'h14;
  localparam logic [7:0] REG_LOCK_TMR = 8'h18;
  localparam logic [7:0] REG_LIVE     = 8'h1c;
  localparam logic [7:0] REG_STICKY   = 8'h20;
  localparam logic [7:0] REG_MASK     = 8'h24;

  localparam int CTRL_LOS_EN_LSB  = 0;
  localparam int CTRL_ZDM_BIT     = 8;
  localparam int CTRL_REF_SEL_LSB = 9;
  localparam int CTRL_XTAL_KEEP   = 12;
  localparam int CTRL_FAST_ACQ    = 13;
  localparam int CTRL_IN_SEL_LSB  = 14;
  localparam int CTRL_PREC_EN     = 16;
  localparam int CTRL_FAST_EN     = 17;
  localparam int CTRL_TIMER_EN    = 18;

  localparam logic [31:0] CTRL_MASK     = 32'h0007_ff1f;
  localparam logic [31:0] CTRL_RESET    = 32'h0003_001f;
  localparam logic [31:0] SENS_MASK     = 32'h000f_ffff;
  localparam logic [31:0] SENS_RESET    = 32'h0001_1111;
  localparam logic [31:0] PREC_MASK     = 32'h1fff_1fff;
  localparam logic [31:0] PREC_RESET    = 32'h0020_0060;
  localparam logic [31:0] FAST_MASK     = 32'h0000_000f;
  localparam logic [31:0] FAST_RESET    = 32'h0000_0000;
  localparam logic [31:0] LOCK_MASK     = 32'h0001_ffff;
  localparam logic [31:0] LOCK_SET_RST  = 32'h0000_000a;
  localparam logic [31:0] LOCK_CLR_RST  = 32'h0000_0001;
  localparam logic [31:0] TMR_MASK      = 32'h00ff_ffff;
  localparam logic [31:0] TMR_RESET     = 32'h0000_0000;
  localparam logic [31:0] STAT_MASK     = 32'h0001_0f1f;

  localparam int STAT_LOS_LSB = 0;
  localparam int STAT_OOF_LSB = 8;
  localparam int STAT_LOL_BIT = 16;
  localparam int SENS_W       = 4;

  localparam logic [2:0] REF_SEL_XTAL = 3'h0;
  localparam logic [2:0] REF_SEL_IN3  = 3'h4;

  localparam int CLK_PERIOD_NS  = 10;
  localparam int LOS_TIMEOUT_NS = 200;
  localparam int LOS_TIMEOUT_CYC = (LOS_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   LOS_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int OUT_HALF_CYC   = 4;
endpackage : icfm_pkg

// *** rtl/icfm_edge_watch.sv ***
// Per-clock edge synchroniser and signal-loss detector
`timescale 1ns/1ps
`default_nettype none
module icfm_edge_watch
  import icfm_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              ce_in,
  input  wire logic              mon_clk_in,
  input  wire logic              enable_in,
  input  wire logic [SENS_W-1:0] sens_in,
  output logic                   edge_out,
  output logic                   loss_out
);
  localparam logic [7:0] TIMEOUT = 8'(LOS_TIMEOUT_CYC);

  logic              sync1_r;
  logic              sync2_r;
  logic              last_r;
  logic [7:0]        period_r;
  logic [SENS_W-1:0] miss_r;
  logic              loss_r;
  logic              edge_w;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
    end else if (ce_in) begin
      sync1_r <= mon_clk_in;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  assign edge_w   = sync2_r & ~last_r;
  assign edge_out = edge_w;
  assign loss_out = loss_r;

  // Period timer; each overrun counts one missing edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      period_r <= 8'h00;
      miss_r   <= '0;
      loss_r   <= 1'b0;
    end else if (ce_in) begin
      if (!enable_in) begin
        period_r <= 8'h00;
        miss_r   <= '0;
        loss_r   <= 1'b0;
      end else if (edge_w) begin
        period_r <= 8'h00;
        miss_r   <= '0;
        loss_r   <= 1'b0;
      end else if (period_r == TIMEOUT) begin
        period_r <= 8'h00;
        if (miss_r >= sens_in) begin
          loss_r <= 1'b1;
        end else begin
          miss_r <= miss_r + 1'b1;
        end
      end else begin
        period_r <= period_r + 8'h01;
      end
    end
  end

  disabled_no_loss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && !enable_in) |=> !loss_out)
    else $error("loss flagged while detector disabled");

  edge_clears_loss_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && enable_in && edge_w) |=> !loss_out)
    else $error("loss kept after a clock edge");
endmodule : icfm_edge_watch
`default_nettype wire

// *** dv/icfm_clk_src.sv ***
// Clock source model for monitored inputs, crystal and feedback
`timescale 1ns/1ps
`default_nettype none
module icfm_clk_src #(
  parameter int HALF_NS = 30
) (
  input  wire logic [4:0] en_in,
  output logic      [3:0] ref_out,
  output logic            xtal_out,
  output logic            fb_out
);
  logic [4:0] clk_r = 5'h00;
  logic       fb_r  = 1'b0;
  // Stopped clocks rest low
  always #(HALF_NS) begin
    clk_r = en_in & ~clk_r;
    fb_r  = ~fb_r;
  end
  assign ref_out  = clk_r[3:0];
  assign xtal_out = clk_r[4];
  assign fb_out   = fb_r;
endmodule : icfm_clk_src
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the input clock fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import icfm_pkg::*;
  logic        clk_in = 1'b0;
  logic        rst_n  = 1'b0;
  logic        cyc    = 1'b0;
  logic        we     = 1'b0;
  logic [7:0]  adr    = 8'h00;
  logic [31:0] dat    = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [4:0]  en     = 5'h1f;
  logic [3:0]  refc;
  logic        xtal, fb, oclk, lol_n, irq_n;
  int          n_mismatch = 0;
  int          total_checks = 0;
  int          cycles = 0;
  int          tog = 0;
  always #5 clk_in = ~clk_in;
  always @(posedge oclk) tog++;
  icfm_clk_src i_icfm_clk_src (.en_in(en), .ref_out(refc), .xtal_out(xtal), .fb_out(fb));
  icfm_monitor #(.PREC_GATE(64), .FAST_GATE(16), .LOCK_GATE(64)) i_icfm_monitor (
    .clk_in(clk_in), .rst_n_in(rst_n), .ce_in(1'b1), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf), .wb_dat_in(dat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .ref_clk_in(refc), .crystal_reference_in(xtal),
    .feedback_clk_in(fb), .out_clk_out(oclk), .lock_loss_pin_n_out(lol_n),
    .interrupt_pin_n_out(irq_n));
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    @(posedge clk_in);
    cyc <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_in); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(r & m, e, what);
  endtask : rdc
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
  endtask : idle
  task automatic t_reset;
    rdc(REG_CTRL, 32'hffffffff, CTRL_RESET, "ctrl reset");
    rdc(REG_LOS_SENS, 32'hffffffff, SENS_RESET, "sens reset");
    rdc(REG_MASK, 32'hffffffff, 32'h0001_0f1f, "mask reset");
    rdc(8'h3c, 32'hffffffff, 32'h0, "unmapped");
    chk({31'h0, irq_n}, 32'h1, "irq masked");
    $display("test reset done");
  endtask : t_reset
  task automatic t_loss;
    idle(100);
    wr(REG_STICKY, STAT_MASK);
    rdc(REG_LIVE, 32'h1f, 32'h0, "live clear");
    en <= 5'h00;
    idle(150);
    rdc(REG_LIVE, 32'h1f, 32'h1f, "live loss");
    en <= 5'h1f;
    idle(30);
    rdc(REG_LIVE, 32'h1f, 32'h0, "live back");
    rdc(REG_STICKY, 32'h1f, 32'h1f, "sticky held");
    wr(REG_STICKY, 32'h1f);
    rdc(REG_STICKY, 32'h1f, 32'h0, "sticky clr");
    $display("test loss done");
  endtask : t_loss
  task automatic t_disable;
    wr(REG_CTRL, CTRL_RESET & ~32'h1);
    en <= 5'h1e;
    idle(150);
    rdc(REG_LIVE, 32'h1f, 32'h0, "disabled det");
    en <= 5'h1f;
    wr(REG_CTRL, CTRL_RESET);
    $display("test disable done");
  endtask : t_disable
  task automatic t_irq;
    wr(REG_STICKY, 32'h1f);
    wr(REG_MASK, 32'h0001_0f1e);
    chk({31'h0, irq_n}, 32'h1, "irq idle");
    en <= 5'h1e;
    idle(150);
    en <= 5'h1f;
    idle(30);
    chk({31'h0, irq_n}, 32'h0, "irq held");
    wr(REG_STICKY, 32'h1);
    #1;
    chk({31'h0, irq_n}, 32'h1, "irq release");
    wr(REG_MASK, 32'h0001_0f1f);
    $display("test irq done");
  endtask : t_irq
  task automatic t_oof;
    wr(REG_CTRL, CTRL_RESET | 32'h0000_0900);
    en <= 5'h1d;
    idle(250);
    rdc(REG_LIVE, 32'hf00, 32'h200, "fast oof");
    wr(REG_CTRL, (CTRL_RESET & ~32'h0002_0000) | 32'h0000_0900);
    rdc(REG_LIVE, 32'hf00, 32'h0, "fast off");
    rdc(REG_STICKY, 32'h200, 32'h200, "oof sticky");
    en <= 5'h1f;
    wr(REG_CTRL, CTRL_RESET);
    $display("test oof done");
  endtask : t_oof
  task automatic t_xtal;
    int t0;
    en <= 5'h0f;
    idle(150);
    t0 = tog;
    idle(40);
    chk(32'(tog - t0), 32'h0, "out stopped");
    wr(REG_CTRL, CTRL_RESET | 32'h1000);
    idle(10);
    t0 = tog;
    idle(40);
    chk({31'h0, tog != t0}, 32'h1, "out kept");
    en <= 5'h1f;
    wr(REG_CTRL, CTRL_RESET);
    $display("test xtal done");
  endtask : t_xtal
  task automatic t_lock;
    for (int i = 0; i < 3000 && lol_n !== 1'b1; i++) @(posedge clk_in);
    chk({31'h0, lol_n}, 32'h1, "locked");
    wr(REG_CTRL, CTRL_RESET | 32'h4000);
    idle(2);
    chk({31'h0, lol_n}, 32'h0, "switch lol");
    rdc(REG_LIVE, 32'h1_0000, 32'h1_0000, "live lol");
    wr(REG_LOCK_TMR, 32'h0000_0200);
    wr(REG_CTRL, CTRL_RESET | 32'h0004_4000);
    idle(600);
    chk({31'h0, lol_n}, 32'h0, "timer holds");
    for (int i = 0; i < 1000 && lol_n !== 1'b1; i++) @(posedge clk_in);
    chk({31'h0, lol_n}, 32'h1, "timer lock");
    $display("test lock done");
  endtask : t_lock
  initial begin
    idle(10);
    rst_n <= 1'b1;
    t_reset();
    t_loss();
    t_disable();
    t_irq();
    t_oof();
    t_xtal();
    t_lock();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
